// File: dv/adcseq_core_model.sv
/* analog core model: takes a one-cycle start, answers with done and data.
   assumes lat comes from the bench; data is valid only with done. */
`timescale 1ns/10ps
module adcseq_core_model
(
  input wire clk, input wire core_start_reg, input wire [3:0] lat,
  input wire [4:0] core_channel_reg,
  output reg core_done = 1'h0, output reg [9:0] core_result = 10'h2a5
);
  reg [4:0] n = 5'h00;
  // a start reloads the count; data flips when not valid so no stale match
  always @(posedge clk)
  begin
    core_done <= !core_start_reg && n == 5'h01;
    core_result <= (core_start_reg || n != 5'h01) ? ~core_result :
      {core_channel_reg, n + lat};
    n <= core_start_reg ? {1'h0, lat} + 5'h02 : n - {4'h0, n != 5'h00};
  end
endmodule

// File: dv/adcseq_props.sv
/* checker on the sequencer ports.
   assumes binding onto adcseq_top, one clock domain. */
`timescale 1ns/10ps
module adcseq_props
(
  input wire clk, input wire sys_rst, input wire conversion_run_bit,
  input wire converter_enable_bit, input wire interrupt_grouping_bit,
  input wire [1:0] trigger_mode, input wire [4:0] channel_select_reg,
  input wire config_write, input wire result_write,
  input wire core_done, input wire core_start_reg,
  input wire [9:0] core_result, input wire [4:0] core_channel_reg,
  input wire conversion_end_irq, input wire busy_reg,
  input wire [9:0] common_result_reg,
  input wire [239:0] per_channel_result_reg
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // a done nothing cancels: no write, stop or timer retrigger
  sequence s_take;
    core_done && busy_reg && !core_start_reg && !config_write &&
      !result_write &&
      conversion_run_bit && converter_enable_bit && trigger_mode != 2'h2;
  endsequence
  a_done_stores: assert property (s_take |=>
    common_result_reg == $past(core_result)) else $error("store lost");
  a_irq_each: assert property (s_take ##0 !interrupt_grouping_bit
    |=> conversion_end_irq) else $error("irq missing");
  a_irq_cause: assert property (conversion_end_irq |->
    $past(core_done)) else $error("irq without done");
  a_start_pulse: assert property (core_start_reg |=>
    !core_start_reg) else $error("start too long");
  a_sw_start: assert property (!$past(sys_rst) &&
    $rose(conversion_run_bit) && converter_enable_bit && !busy_reg &&
    trigger_mode == 2'h0 && !config_write |=> core_start_reg)
    else $error("run ignored");
  a_run_stop: assert property (!conversion_run_bit |=>
    !busy_reg && !core_start_reg) else $error("kept running");
  a_write_mask: assert property ((config_write || result_write) &&
    trigger_mode != 2'h0 |=> !core_start_reg) else $error("trigger kept");
  a_scan_range: assert property (core_start_reg && !config_write
    |-> core_channel_reg <= channel_select_reg) else $error("bad channel");
  a_reset_clear: assert property (disable iff (1'h0) sys_rst |=>
    common_result_reg == 10'h000 && per_channel_result_reg == 240'h0)
    else $error("not cleared");
endmodule
bind adcseq_top adcseq_props u_adcseq_props (.*);

// File: dv/adcseq_top_bench.sv
/* bench: corner and random runs against the core model.
   assumes model and checker files compile first. */
`timescale 1ns/10ps
module adcseq_top_bench;
  reg clk = 1'h0, sys_rst = 1'h1, conversion_run_bit = 1'h0;
  reg converter_enable_bit = 1'h1, interrupt_grouping_bit = 1'h0;
  reg config_write = 1'h0, result_write = 1'h0, external_trigger_pin = 1'h0;
  reg timer_event_a = 1'h0, timer_event_b = 1'h0;
  reg [1:0] operation_mode = 2'h0, trigger_mode = 2'h0, es = 2'h1, ts = 2'h1;
  reg [4:0] channel_select_reg = 5'h00;
  reg [3:0] lat = 4'h3;
  reg [31:0] seed = 32'h9cefffbb;
  wire core_done, core_start_reg, conversion_end_irq, busy_reg;
  wire wait_trigger_reg;
  wire [4:0] core_channel_reg;
  wire [9:0] core_result, common_result_reg;
  wire [239:0] per_channel_result_reg;
  integer fail_count = 0, compares = 0, nst = 0, nirq = 0, i, a;
  adcseq_top u_adcseq_top (.*, .edge_select_hi(es[1]),
    .edge_select_lo(es[0]), .timer_source_select_hi(ts[1]),
    .timer_source_select_lo(ts[0]));
  adcseq_core_model u_adcseq_core_model (.*);
  // 4 ns clock
  initial
    forever #2 clk = ~clk;
  // count starts and interrupts
  always @(posedge clk)
  begin
    nst = nst + core_start_reg;
    nirq = nirq + conversion_end_irq;
  end
  function automatic [31:0] xs(input [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task chk(input [63:0] nm, input [9:0] e, g);
    compares++;
    if (e !== g)
    begin
      fail_count++;
      $display("mismatch %0s exp %0h got %0h", nm, e, g);
    end
  endtask
  // one-cycle write strobe; only between edges
  task cfg(input [1:0] m, t, input [4:0] s);
    operation_mode = m;
    trigger_mode = t;
    channel_select_reg = s;
    config_write = 1'h1;
    #4 config_write = 1'h0;
  endtask
  task complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #20000 fail_count++;
    complete_run;
  end
  // inputs move 1 ns after an edge; waits are whole cycles
  initial
  begin
    #19 sys_rst = 1'h0;
    chk("reset", 10'h000, common_result_reg);
    cfg(2'h0, 2'h0, 5'h05);
    conversion_run_bit = 1'h1;
    #240 chk("irqs", 10'h001, 10'(nirq > 5));
    chk("chan", common_result_reg, per_channel_result_reg[59:50]);
    conversion_run_bit = 1'h0;
    #8 a = nst;
    #120 chk("stop", 10'(a), 10'(nst));
    cfg(2'h1, 2'h0, 5'h03);
    conversion_run_bit = 1'h1;
    #100 while (!busy_reg || core_start_reg) #4;
    cfg(2'h1, 2'h0, 5'h03);
    while (!core_start_reg) #4;
    chk("abort", 10'h000, {5'h00, core_channel_reg});
    // a result write mid-conversion restarts like a config write
    while (!busy_reg || core_start_reg) #4;
    result_write = 1'h1;
    #4 result_write = 1'h0;
    chk("rwrite", 10'h001, {9'h000, core_start_reg});
    chk("rwchan", 10'h000, {5'h00, core_channel_reg});
    // random modes, channels and latencies
    for (i = 0; i < 6; i++)
    begin
      conversion_run_bit = 1'h0;
      seed = xs(seed);
      lat = seed[3:0];
      cfg(seed[6:5], 2'h0, seed[12:8] % 5'h18);
      a = nst;
      conversion_run_bit = 1'h1;
      #360 if (!seed[5]) chk("sel", common_result_reg,
        per_channel_result_reg[10 * channel_select_reg +: 10]);
      if (seed[6:5] == 2'h2) chk("once", 10'h001, 10'(nst - a));
    end
    // external pin under falling, rising and both edges
    conversion_run_bit = 1'h0;
    converter_enable_bit = 1'h0;
    lat = 4'h2;
    cfg(2'h2, 2'h1, 5'h07);
    converter_enable_bit = 1'h1;
    conversion_run_bit = 1'h1;
    for (i = 0; i < 3; i++)
    begin
      es = 2'(i);
      a = nst;
      #8 external_trigger_pin = 1'h1;
      #80 external_trigger_pin = 1'h0;
      #80 chk("edges", 10'(i / 2 + 1), 10'(nst - a));
    end
    // grouped one-shot scan of three inputs
    interrupt_grouping_bit = 1'h1;
    es = 2'h1;
    cfg(2'h3, 2'h1, 5'h02);
    a = nirq;
    external_trigger_pin = 1'h1;
    #160 chk("group", 10'h001, 10'(nirq - a));
    chk("rewait", 10'h001, {9'h000, wait_trigger_reg});
    // timer b chosen: a is ignored, b restarts a long conversion
    conversion_run_bit = 1'h0;
    converter_enable_bit = 1'h0;
    lat = 4'hf;
    cfg(2'h2, 2'h2, 5'h04);
    converter_enable_bit = 1'h1;
    conversion_run_bit = 1'h1;
    a = nst;
    timer_event_a = 1'h1;
    #80 timer_event_b = 1'h1;
    #32 timer_event_b = 1'h0;
    #8 timer_event_b = 1'h1;
    #160 chk("timer", 10'h002, 10'(nst - a));
    complete_run;
  end
endmodule

// File: hdl/adcseq_defines.vh
/*
  constants for the converter trigger and mode sequencer.
  assumes plain verilog-2005 and inclusion by bare name.
*/
`ifndef ADCSEQ_DEFINES_VH
`define ADCSEQ_DEFINES_VH
// trigger mode encodings
`define ADCSEQ_TRG_SW 2'h0
`define ADCSEQ_TRG_EXT 2'h1
`define ADCSEQ_TRG_TMR 2'h2
// edge select encodings
`define ADCSEQ_EDGE_FALL 2'h0
`define ADCSEQ_EDGE_RISE 2'h1
`define ADCSEQ_EDGE_BOTH 2'h2
// timer source select encodings
`define ADCSEQ_TMR_A 2'h0
`define ADCSEQ_TMR_B 2'h1
// operation mode field: bit 1 one-shot, bit 0 scan
`define ADCSEQ_OP_ONESHOT 1
`define ADCSEQ_OP_SCAN 0
// channel and result widths
`define ADCSEQ_CH_W 5
`define ADCSEQ_NCH 24
`define ADCSEQ_RES_W 10
`define ADCSEQ_CH_FIRST 5'h00
`define ADCSEQ_CH_ONE 5'h01
`define ADCSEQ_RES_RST 10'h000
`endif

// File: hdl/adcseq_top.v
/*
  converter trigger and mode sequencer: picks the conversion start source,
  walks select and scan modes, stores results, pulses the end interrupt.
  assumes the analog core takes a one-cycle start and answers with a
  one-cycle done plus data; config writes arrive as one-cycle strobes.
*/
// Function
// - software run bit starts selected channel conversion
// - software continuous mode repeats conversions until run cleared
// - config register write aborts running conversion
// - software abort redoes conversion or restarts scan
// - external trigger edge chosen by two bits
// - external mode waits for pin edge
// - hardware result stored in common and channel registers
// - grouping off: interrupt each store, rewait trigger
// - grouping on: interrupt after last channel, rewait
// - hardware mode config write aborts, rewaits trigger
// - timer source select picks event, rising edge
// - timer mode waits for selected timer event
// - timer trigger during conversion restarts it
// - four operation modes from mode bits
// - continuous select repeats one channel, stores both
// - continuous select interrupts each conversion until stopped
// - write starts when idle with run set, restarts when converting
// - triggers during config write are ignored
// - scan runs first input up to selected
// - one-shot select converts once then stops
// - one-shot hardware returns to trigger wait
// - reset clears all result registers
`timescale 1ns/10ps
`include "adcseq_defines.vh"
module adcseq_top
(
  input wire clk,
  input wire sys_rst,
  input wire conversion_run_bit,
  input wire converter_enable_bit,
  input wire [1:0] operation_mode,
  input wire interrupt_grouping_bit,
  input wire [1:0] trigger_mode,
  input wire edge_select_hi,
  input wire edge_select_lo,
  input wire timer_source_select_hi,
  input wire timer_source_select_lo,
  input wire [4:0] channel_select_reg,
  input wire config_write,
  input wire result_write,
  input wire external_trigger_pin,
  input wire timer_event_a,
  input wire timer_event_b,
  input wire core_done,
  input wire [9:0] core_result,
  output reg core_start_reg,
  output reg [4:0] core_channel_reg,
  output reg conversion_end_irq,
  output reg [9:0] common_result_reg,
  output reg [239:0] per_channel_result_reg,
  output reg busy_reg,
  output reg wait_trigger_reg
);
  // one-hot sequencer states:
  //   idle - nothing running; software mode waits for the run bit to rise
  //   wait - hardware mode armed, looking for a pin or timer edge
  //   conv - the analog core is working on core_channel_reg
  // one-hot keeps the decode of busy and wait to a single flop each,
  // at the cost of five spare codes that the default branch absorbs
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_CONV = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [4:0] chan_next;
  reg start_next;
  reg irq_next;
  reg store;
  reg [239:0] per_channel_result_next;
  integer idx;
  // run bit delay for its rising edge; the run bit is a register bit on
  // this clock, so it needs no synchroniser, unlike the pins below.
  // each async source gets s1, s2 and a delay flop for edge finding
  reg run_d_reg;
  reg ext_s1_reg;
  reg ext_s2_reg;
  reg ext_d_reg;
  reg ta_s1_reg;
  reg ta_s2_reg;
  reg ta_d_reg;
  reg tb_s1_reg;
  reg tb_s2_reg;
  reg tb_d_reg;
  wire hw_mode;
  wire scan_mode;
  wire oneshot;
  wire ext_rise;
  wire ext_fall;
  reg ext_hit;
  wire tmr_sel;
  wire tmr_hit;
  wire hw_trig;
  wire wr_any;
  wire first_start;
  wire last_chan;
  wire [4:0] first_chan;

  // mode decode; code 3 of the trigger field counts as hardware but has
  // no source, so the sequencer just sits in wait there.
  // scan starts at the first input, select at the named one.
  // last_chan is true for every conversion in select mode, so the
  // grouping bit has no effect there
  assign hw_mode = (trigger_mode != `ADCSEQ_TRG_SW);
  assign scan_mode = operation_mode[`ADCSEQ_OP_SCAN];
  assign oneshot = operation_mode[`ADCSEQ_OP_ONESHOT];
  assign wr_any = config_write | result_write;
  assign first_chan = scan_mode ? `ADCSEQ_CH_FIRST : channel_select_reg;
  assign last_chan = !scan_mode || (core_channel_reg >= channel_select_reg);
  assign first_start = conversion_run_bit & ~run_d_reg;

  // pins and timer events pass two flops; edges read the second flop only
  // this costs two cycles of trigger latency, which is the price of
  // never letting a metastable first flop reach the sequencer
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_d_reg <= 1'b0;
      ta_s1_reg <= 1'b0;
      ta_s2_reg <= 1'b0;
      ta_d_reg <= 1'b0;
      tb_s1_reg <= 1'b0;
      tb_s2_reg <= 1'b0;
      tb_d_reg <= 1'b0;
      run_d_reg <= 1'b0;
    end
    else
    begin
      ext_s1_reg <= external_trigger_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg <= ext_s2_reg;
      ta_s1_reg <= timer_event_a;
      ta_s2_reg <= ta_s1_reg;
      ta_d_reg <= ta_s2_reg;
      tb_s1_reg <= timer_event_b;
      tb_s2_reg <= tb_s1_reg;
      tb_d_reg <= tb_s2_reg;
      run_d_reg <= conversion_run_bit;
    end
  end

  assign ext_rise = ext_s2_reg & ~ext_d_reg;
  assign ext_fall = ~ext_s2_reg & ext_d_reg;

  // edge choice for the external pin
  // the unused fourth code yields no trigger at all
  always @*
  begin
    case ({edge_select_hi, edge_select_lo})
      `ADCSEQ_EDGE_FALL: ext_hit = ext_fall;
      `ADCSEQ_EDGE_RISE: ext_hit = ext_rise;
      `ADCSEQ_EDGE_BOTH: ext_hit = ext_rise | ext_fall;
      default: ext_hit = 1'b0;
    endcase
  end

  // timer source: rising edge of the chosen event
  assign tmr_sel = ({timer_source_select_hi, timer_source_select_lo} ==
                    `ADCSEQ_TMR_B);
  assign tmr_hit = tmr_sel ? (tb_s2_reg & ~tb_d_reg)
                           : (ta_s2_reg & ~ta_d_reg);
  // a trigger during a register write is dropped, not held
  // software that writes often may therefore lose edges; that is
  // intended, a held trigger would start on stale settings
  assign hw_trig = ~wr_any & ((trigger_mode == `ADCSEQ_TRG_EXT) ? ext_hit :
                   (trigger_mode == `ADCSEQ_TRG_TMR) ? tmr_hit
                                                      : 1'b0);

  // sequencer next state
  // priority inside conv, highest first:
  //   enable or run low - drop to idle at once
  //   register write    - abort, restart or rewait
  //   timer retrigger   - restart from the first channel
  //   core done         - store, interrupt and step the channel
  // a done in the same cycle as a start belongs to the old conversion
  always @*
  begin
    state_next = state_reg;
    chan_next = core_channel_reg;
    start_next = 1'b0;
    irq_next = 1'b0;
    store = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (converter_enable_bit && conversion_run_bit)
        begin
          if (hw_mode)
            state_next = ST_WAIT;
          else if (first_start || wr_any)
          begin
            state_next = ST_CONV;
            chan_next = first_chan;
            start_next = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        if (!converter_enable_bit || !conversion_run_bit)
          state_next = ST_IDLE;
        else if (hw_trig)
        begin
          state_next = ST_CONV;
          chan_next = first_chan;
          start_next = 1'b1;
        end
      end
      default:
      begin
        if (!converter_enable_bit || !conversion_run_bit)
        begin
          state_next = ST_IDLE;
        end
        else if (wr_any)
        begin
          // abort: software redoes from the first channel, hw rewaits
          if (hw_mode)
            state_next = ST_WAIT;
          else
          begin
            chan_next = first_chan;
            start_next = 1'b1;
          end
        end
        else if (hw_trig && trigger_mode == `ADCSEQ_TRG_TMR)
        begin
          chan_next = first_chan;
          start_next = 1'b1;
        end
        else if (core_done && !core_start_reg)
        begin
          store = 1'b1;
          irq_next = !interrupt_grouping_bit || last_chan;
          if (!last_chan)
          begin
            chan_next = core_channel_reg + `ADCSEQ_CH_ONE;
            start_next = 1'b1;
          end
          else if (hw_mode)
            state_next = ST_WAIT;
          else if (oneshot)
            state_next = ST_IDLE;
          else
          begin
            chan_next = first_chan;
            start_next = 1'b1;
          end
        end
      end
    endcase
  end

  // per-channel result slots: only the converted channel's slot moves;
  // the loop builds a small mux per slot rather than a wide shifter
  always @*
  begin
    per_channel_result_next = per_channel_result_reg;
    for (idx = 0; idx < `ADCSEQ_NCH; idx = idx + 1)
      if (store && idx == core_channel_reg)
        per_channel_result_next[idx*`ADCSEQ_RES_W +: `ADCSEQ_RES_W] =
          core_result;
  end

  // state, strobes and results; results clear only on reset
  // a register write does not clear results, software keeps old data
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      core_channel_reg <= `ADCSEQ_CH_FIRST;
      core_start_reg <= 1'b0;
      conversion_end_irq <= 1'b0;
      common_result_reg <= `ADCSEQ_RES_RST;
      per_channel_result_reg <= {`ADCSEQ_NCH{`ADCSEQ_RES_RST}};
      busy_reg <= 1'b0;
      wait_trigger_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      core_channel_reg <= chan_next;
      core_start_reg <= start_next;
      conversion_end_irq <= irq_next;
      busy_reg <= (state_next == ST_CONV);
      wait_trigger_reg <= (state_next == ST_WAIT);
      per_channel_result_reg <= per_channel_result_next;
      if (store)
        common_result_reg <= core_result;
    end
  end
endmodule
